// File: verilog/sosc_pkg.sv
package sosc_pkg;
   localparam logic [19:0] OSC_STABLE_STATUS_ADDR = 20'hfffa2;
   localparam logic [19:0] OSC_STABLE_WAIT_SELECT_ADDR = 20'hfffa3;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] WAIT_SEL_RESET = 3'h7;
   localparam int WAIT_SEL_W = 3;
   localparam int CNT_W = 19;
   // Threshold exponents per select code / per status flag
   localparam int EXP_0 = 8;
   localparam int EXP_1 = 9;
   localparam int EXP_2 = 10;
   localparam int EXP_3 = 11;
   localparam int EXP_4 = 13;
   localparam int EXP_5 = 15;
   localparam int EXP_6 = 17;
   localparam int EXP_7 = 18;

   typedef enum logic [2:0] {
      SOSC_RUN = 3'b001,
      SOSC_HALT = 3'b010,
      SOSC_STOP = 3'b100
   } sosc_state_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic wr_byte;
      logic rd_byte;
      logic [2:0] bit_sel;
   } sosc_bus_t;
endpackage : sosc_pkg

// File: verilog/sosc_standby.sv
// Overview of operation
// - Halt instruction gates CPU clock; running oscillators keep oscillating.
// - Stop instruction shuts the main oscillator (main_osc_enable low).
// - Interrupt releases stop; X1 as CPU clock inserts stabilization wait.
// - Registers, memory and port latches are retained in both standby states.
// - Status clears on reset, stop instruction, or X1 stop control set.
// - Flags set one at a time at thresholds, staying set until cleared.
// - Counter counts only up to the selected wait.
// - Status readable by single-bit or whole-byte access.
// - With X1 CPU clock, execution held until selected wait elapses.
// - Select codes 0..7 map to 2^8..2^18 X1 periods.
// - Select written by byte only, resets to 07H, upper bits read zero.
// - Counting starts only once X1 actually oscillates.
// - Unmasked interrupt releases halt; vectored or next instruction.
// - Pending unmasked interrupt at stop falls back to halt, then waits.
module sosc_standby #(
   parameter int CNT_WIDTH = sosc_pkg::CNT_W
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire sosc_pkg::sosc_bus_t bus,
   output logic [7:0] rdata,
   input wire logic halt_instr,
   input wire logic stop_instr,
   input wire logic irq_pending,
   input wire logic irq_ack_enable,
   input wire logic x1_is_cpu_clock,
   input wire logic x1_osc_stop_ctrl,
   input wire logic x1_clk_tick,
   input wire logic x1_osc_running,
   output logic cpu_clk_enable,
   output logic main_osc_enable,
   output logic vector_request,
   output logic retain_state,
   output logic [2:0] standby_state
);
   // Longest threshold must fit the counter
   if (CNT_WIDTH < sosc_pkg::EXP_7 + 1) begin : g_width_check
      $error("CNT_WIDTH too small for longest wait");
   end

   // Pin inputs from the oscillator domain pass two flops
   logic [1:0] tick_sync;
   logic [1:0] run_sync;
   logic tick_prev;
   logic tick_edge;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tick_sync <= 2'h0;
         run_sync <= 2'h0;
         tick_prev <= 1'b0;
      end else begin
         tick_sync <= {tick_sync[0], x1_clk_tick};
         run_sync <= {run_sync[0], x1_osc_running};
         tick_prev <= tick_sync[1];
      end
   end
   assign tick_edge = tick_sync[1] & ~tick_prev;

   sosc_pkg::sosc_state_t state;
   sosc_pkg::sosc_state_t next_state;
   logic [2:0] wait_sel;
   logic [2:0] next_wait_sel;
   logic [7:0] status;
   logic [7:0] next_status;
   logic [CNT_WIDTH-1:0] cnt;
   logic [CNT_WIDTH-1:0] next_cnt;
   logic waiting;
   logic next_waiting;
   logic [7:0] rdata_q;
   logic [7:0] next_rdata;
   logic vec_q;
   logic next_vec;

   // Status bit 7 is the 2^8 flag, bit 0 the 2^18 flag
   localparam int EXPS [8] = '{sosc_pkg::EXP_0, sosc_pkg::EXP_1, sosc_pkg::EXP_2, sosc_pkg::EXP_3,
                               sosc_pkg::EXP_4, sosc_pkg::EXP_5, sosc_pkg::EXP_6, sosc_pkg::EXP_7};
   logic [7:0] reached;
   logic [7:0] allowed;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_thr
         assign reached[7-g] = cnt >= CNT_WIDTH'(1 << EXPS[g]);
         assign allowed[7-g] = (3'(g) <= wait_sel);
      end
   endgenerate

   logic wait_done;
   logic stable_flag_2p8;
   logic stable_flag_2p18;
   assign stable_flag_2p8 = status[7];
   assign stable_flag_2p18 = status[0];
   assign wait_done = status[3'd7 - wait_sel];
   logic [2:0] wait_sel_bit;
   assign wait_sel_bit = wait_sel;

   always_comb begin
      next_state = state;
      next_wait_sel = wait_sel;
      next_status = status;
      next_cnt = cnt;
      next_waiting = waiting;
      next_vec = 1'b0;
      next_rdata = rdata_q;
      // Count only while X1 truly oscillates and the selected wait is unmet
      if (run_sync[1] && tick_edge && !wait_done) begin
         next_cnt = cnt + CNT_WIDTH'(1);
      end
      next_status = status | (reached & allowed);
      unique case (state)
         sosc_pkg::SOSC_RUN: begin
            if (stop_instr) begin
               next_status = sosc_pkg::STATUS_RESET;
               next_cnt = '0;
               // Pending unmasked request drops straight to halt with wait
               next_state = irq_pending ? sosc_pkg::SOSC_HALT : sosc_pkg::SOSC_STOP;
               next_waiting = irq_pending;
            end else if (halt_instr) begin
               next_state = sosc_pkg::SOSC_HALT;
            end
         end
         sosc_pkg::SOSC_HALT: begin
            if (waiting) begin
               // Hold CPU until selected wait passes when X1 drives it
               if (wait_done || !x1_is_cpu_clock) begin
                  next_waiting = 1'b0;
                  next_state = sosc_pkg::SOSC_RUN;
                  next_vec = irq_ack_enable;
               end
            end else if (irq_pending) begin
               next_state = sosc_pkg::SOSC_RUN;
               next_vec = irq_ack_enable;
            end
         end
         sosc_pkg::SOSC_STOP: begin
            if (irq_pending) begin
               next_state = sosc_pkg::SOSC_HALT;
               next_waiting = 1'b1;
            end
         end
         default: begin
            next_state = sosc_pkg::SOSC_RUN;
         end
      endcase
      if (x1_osc_stop_ctrl) begin
         next_status = sosc_pkg::STATUS_RESET;
         next_cnt = '0;
      end
      // Byte-wide write only; bit writes ignored
      if (bus.wr && bus.wr_byte && bus.addr == sosc_pkg::OSC_STABLE_WAIT_SELECT_ADDR) begin
         next_wait_sel = bus.wdata[2:0];
      end
      if (bus.rd) begin
         if (bus.addr == sosc_pkg::OSC_STABLE_STATUS_ADDR) begin
            // Single-bit read returns chosen bit in bit 0
            next_rdata = bus.rd_byte ? status : {7'h00, status[bus.bit_sel]};
         end else if (bus.addr == sosc_pkg::OSC_STABLE_WAIT_SELECT_ADDR) begin
            next_rdata = {5'h00, wait_sel};
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= sosc_pkg::SOSC_RUN;
         wait_sel <= sosc_pkg::WAIT_SEL_RESET;
         status <= sosc_pkg::STATUS_RESET;
         cnt <= '0;
         waiting <= 1'b0;
         rdata_q <= 8'h00;
         vec_q <= 1'b0;
      end else begin
         state <= next_state;
         wait_sel <= next_wait_sel;
         status <= next_status;
         cnt <= next_cnt;
         waiting <= next_waiting;
         rdata_q <= next_rdata;
         vec_q <= next_vec;
      end
   end

   assign rdata = rdata_q;
   assign vector_request = vec_q;
   assign standby_state = state;
   assign cpu_clk_enable = (state == sosc_pkg::SOSC_RUN);
   // Oscillators only stop in deep stop; halt leaves them alone
   assign main_osc_enable = (state != sosc_pkg::SOSC_STOP);
   // Standby freezes CPU side; block itself never clears other state
   assign retain_state = (state != sosc_pkg::SOSC_RUN);

   // Status flags, wait counter and tick sync
   stable_order_a: assert property (@(posedge ref_clk) disable iff (reset)
      (status[6:0] & ~status[7:1]) == 7'h00)
      else $error("status not thermometer");
   flag_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
      (status[7] && !stop_instr && !x1_osc_stop_ctrl && state != sosc_pkg::SOSC_RUN) |=> status[7])
      else $error("flag dropped");
   stop_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state == sosc_pkg::SOSC_RUN && stop_instr) |=> status == 8'h00)
      else $error("stop no clear");
   x1_osc_stop_ctrl_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
      x1_osc_stop_ctrl |=> status == 8'h00)
      else $error("x1 stop no clear");
   flag_reach_a: assert property (@(posedge ref_clk) disable iff (reset)
      (status & ~reached) == 8'h00)
      else $error("flag before threshold");
   flag_order_a: assert property (@(posedge ref_clk) disable iff (reset)
      stable_flag_2p18 |-> stable_flag_2p8)
      else $error("longest flag without shortest");
   // A lowered select may leave older flags; only new flags are limited
   limit_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
      (status & ~$past(status) & ~$past(allowed)) == 8'h00)
      else $error("past selected wait");
   cnt_limit_a: assert property (@(posedge ref_clk) disable iff (reset)
      wait_done |=> $stable(cnt) || cnt == '0)
      else $error("count past selected wait");
   cnt_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
      !run_sync[1] |=> $stable(cnt) || cnt == '0)
      else $error("count without oscillator");
   sync_edge_a: assert property (@(posedge ref_clk) disable iff (reset)
      tick_edge |=> !tick_edge)
      else $error("tick counted twice");

   // Standby state machine
   stop_osc_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state == sosc_pkg::SOSC_RUN && stop_instr && !irq_pending) |=> !main_osc_enable)
      else $error("osc not stopped");
   halt_clk_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state == sosc_pkg::SOSC_RUN && halt_instr && !stop_instr) |=> !cpu_clk_enable && main_osc_enable)
      else $error("halt gating wrong");
   halt_osc_a: assert property (@(posedge ref_clk) disable iff (reset)
      state == sosc_pkg::SOSC_HALT |-> main_osc_enable)
      else $error("halt stopped oscillator");
   instr_ignore_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state != sosc_pkg::SOSC_RUN && (halt_instr || stop_instr) && !irq_pending && !waiting) |=> $stable(state))
      else $error("instruction taken in standby");
   state_onehot_a: assert property (@(posedge ref_clk) disable iff (reset)
      $onehot(state))
      else $error("state not one-hot");
   stop_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state == sosc_pkg::SOSC_STOP && irq_pending) |=> state == sosc_pkg::SOSC_HALT && waiting)
      else $error("stop not released");
   int_release_a: assert property (@(posedge ref_clk) disable iff (reset)
      (waiting && !x1_is_cpu_clock) |=> cpu_clk_enable)
      else $error("internal clock release late");
   fallback_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state == sosc_pkg::SOSC_RUN && stop_instr && irq_pending) |=> state == sosc_pkg::SOSC_HALT && waiting)
      else $error("no fallback to halt");
   hold_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
      (waiting && x1_is_cpu_clock && !wait_done) |=> !cpu_clk_enable)
      else $error("cpu ran early");
   release_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      ($fell(waiting) && $past(x1_is_cpu_clock)) |-> status[3'd7 - wait_sel_bit])
      else $error("released before selected flag");
   halt_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state == sosc_pkg::SOSC_HALT && !waiting && irq_pending) |=> cpu_clk_enable)
      else $error("halt not released");
   vec_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
      vector_request |-> cpu_clk_enable && $past(irq_ack_enable))
      else $error("vector without enable");
   vec_single_a: assert property (@(posedge ref_clk) disable iff (reset)
      vector_request |=> !vector_request)
      else $error("vector longer than a cycle");
   stop_retain_a: assert property (@(posedge ref_clk) disable iff (reset)
      state == sosc_pkg::SOSC_STOP |-> !cpu_clk_enable && retain_state)
      else $error("stop not retaining");
   retain_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
      (retain_state && !bus.wr) |=> $stable(wait_sel))
      else $error("select lost in standby");
   // Checked through reset, so no disable here
   reset_run_a: assert property (@(posedge ref_clk)
      reset |=> state == sosc_pkg::SOSC_RUN && wait_sel == sosc_pkg::WAIT_SEL_RESET && status == 8'h00)
      else $error("reset values wrong");

   // Register access
   sel_byte_a: assert property (@(posedge ref_clk) disable iff (reset)
      (bus.wr && !bus.wr_byte) |=> $stable(wait_sel))
      else $error("bit write changed select");
   sel_write_a: assert property (@(posedge ref_clk) disable iff (reset)
      (bus.wr && bus.wr_byte && bus.addr == sosc_pkg::OSC_STABLE_WAIT_SELECT_ADDR) |=> wait_sel == $past(bus.wdata[2:0]))
      else $error("select write lost");
   sel_upper_a: assert property (@(posedge ref_clk) disable iff (reset)
      ($past(bus.rd) && $past(bus.addr) == sosc_pkg::OSC_STABLE_WAIT_SELECT_ADDR) |-> rdata[7:3] == 5'h00)
      else $error("upper select bits");
   status_read_a: assert property (@(posedge ref_clk) disable iff (reset)
      (bus.rd && bus.rd_byte && bus.addr == sosc_pkg::OSC_STABLE_STATUS_ADDR) |=> rdata == $past(status))
      else $error("status byte read wrong");
   bit_read_a: assert property (@(posedge ref_clk) disable iff (reset)
      (bus.rd && !bus.rd_byte && bus.addr == sosc_pkg::OSC_STABLE_STATUS_ADDR)
      |=> rdata == {7'h00, $past(status[bus.bit_sel])})
      else $error("status bit read wrong");
   rd_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      !bus.rd |=> $stable(rdata))
      else $error("read data changed without read");
   unmapped_a: assert property (@(posedge ref_clk) disable iff (reset)
      (bus.rd && bus.addr != sosc_pkg::OSC_STABLE_STATUS_ADDR && bus.addr != sosc_pkg::OSC_STABLE_WAIT_SELECT_ADDR)
      |=> rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : sosc_standby

// File: test/sosc_standby_test.sv
module sosc_standby_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [19:0] ST = sosc_pkg::OSC_STABLE_STATUS_ADDR;
   localparam logic [19:0] SL = sosc_pkg::OSC_STABLE_WAIT_SELECT_ADDR;
   logic ref_clk = 0;
   logic reset = 1;
   logic halt_instr = 0;
   logic stop_instr = 0;
   logic irq_pending = 0;
   logic irq_ack_enable = 0;
   logic x1_is_cpu_clock = 1;
   logic x1_osc_stop_ctrl = 0;
   logic x1_clk_tick = 0;
   logic x1_osc_running = 0;
   logic cpu_clk_enable, main_osc_enable, vector_request, retain_state;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [2:0] standby_state;
   sosc_pkg::sosc_bus_t bus = '0;
   int n_fail = 0;
   int total_checks = 0;
   int n, vec;

   sosc_standby sosc_standby_i (.ref_clk(ref_clk), .reset(reset), .bus(bus), .rdata(rdata),
      .halt_instr(halt_instr), .stop_instr(stop_instr), .irq_pending(irq_pending),
      .irq_ack_enable(irq_ack_enable), .x1_is_cpu_clock(x1_is_cpu_clock),
      .x1_osc_stop_ctrl(x1_osc_stop_ctrl), .x1_clk_tick(x1_clk_tick), .x1_osc_running(x1_osc_running),
      .cpu_clk_enable(cpu_clk_enable), .main_osc_enable(main_osc_enable),
      .vector_request(vector_request), .retain_state(retain_state), .standby_state(standby_state));

   initial forever #12.5 ref_clk = ~ref_clk;
   // X1 at a quarter of ref_clk, edges on falling edges of ref_clk
   initial forever #50 x1_clk_tick = ~x1_clk_tick;

   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : cyc

   task rd(input logic [19:0] a, input logic whole, input logic [2:0] b);
      @(negedge ref_clk);
      bus.addr = a;
      bus.rd = 1;
      bus.rd_byte = whole;
      bus.bit_sel = b;
      @(negedge ref_clk);
      bus.rd = 0;
      d = rdata;
   endtask : rd

   task wr(input logic [19:0] a, input logic [7:0] v, input logic whole);
      @(negedge ref_clk);
      bus.addr = a;
      bus.wdata = v;
      bus.wr = 1;
      bus.wr_byte = whole;
      @(negedge ref_clk);
      bus.wr = 0;
   endtask : wr

   task fire(input logic is_halt);
      @(negedge ref_clk);
      if (is_halt) halt_instr = 1;
      else stop_instr = 1;
      @(negedge ref_clk);
      halt_instr = 0;
      stop_instr = 0;
   endtask : fire

   // Bounded wait for RUN, counting vector pulses on the way
   task wait_run(input int lim);
      n = 0;
      vec = 0;
      while (standby_state !== 3'b001 && n < lim) begin
         @(negedge ref_clk);
         n++;
         if (vector_request === 1'b1) vec++;
      end
      @(negedge ref_clk);
      if (vector_request === 1'b1) vec++;
   endtask : wait_run

   function automatic logic [7:0] outs();
      return {2'h0, cpu_clk_enable, main_osc_enable, retain_state, standby_state};
   endfunction : outs

   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   initial begin
      #(30000 * 25);
      n_fail++;
      report_and_stop;
   end

   initial begin
      cyc(8);
      reset = 0;
      rd(ST, 1, 0); chk("status", d, 8'h00);
      rd(SL, 1, 0); chk("select", d, 8'h07);
      chk("outs", outs(), 8'h31);
      wr(SL, 8'hf8, 0); rd(SL, 1, 0); chk("select", d, 8'h07);
      wr(SL, 8'hf9, 1); rd(SL, 1, 0); chk("select", d, 8'h01);
      wr(ST, 8'hff, 1); rd(ST, 1, 0); chk("status", d, 8'h00);
      rd(20'hfffa4, 1, 0); chk("unmapped", d, 8'h00);
      $display("registers done");
      fire(1); cyc(2); chk("outs", outs(), 8'h1a);
      irq_pending = 1;
      wait_run(8); chk("outs", outs(), 8'h31); chk("vec", 8'(vec), 8'h00);
      irq_pending = 0;
      $display("halt done");
      irq_ack_enable = 1;
      fire(0); cyc(2); chk("outs", outs(), 8'h0c);
      rd(ST, 1, 0); chk("status", d, 8'h00);
      cyc(20); chk("outs", outs(), 8'h0c);
      irq_pending = 1;
      // Oscillator not yet started: the wait must not advance
      cyc(40); chk("state", {5'h0, standby_state}, 8'h02);
      x1_osc_running = 1;
      wait_run(4000); chk("wait", {7'h0, n >= 2000 && n < 2200}, 8'h01);
      chk("vec", 8'(vec), 8'h01);
      irq_pending = 0;
      rd(ST, 1, 0); chk("status", d, 8'hc0);
      rd(ST, 0, 7); chk("bit7", d, 8'h01);
      rd(ST, 0, 5); chk("bit5", d, 8'h00);
      $display("stop done");
      x1_osc_stop_ctrl = 1;
      cyc(4); rd(ST, 1, 0); chk("status", d, 8'h00);
      x1_osc_stop_ctrl = 0;
      cyc(2200); rd(ST, 1, 0); chk("status", d, 8'hc0);
      wr(SL, 8'h03, 1);
      cyc(6300); rd(ST, 1, 0); chk("status", d, 8'hf0);
      $display("run count done");
      x1_is_cpu_clock = 0;
      irq_pending = 1;
      fire(0); cyc(1); wait_run(6); chk("outs", outs(), 8'h31);
      rd(ST, 1, 0); chk("status", d, 8'h00);
      irq_pending = 0;
      fire(1); cyc(2); reset = 1; cyc(2); reset = 0; cyc(1);
      chk("outs", outs(), 8'h31);
      $display("fallback and reset done");
      report_and_stop;
   end
endmodule : sosc_standby_test
